// File: core/aiq_regs.svh
// Purpose: Register map, field positions, reset values and limits of the sample unpacker.
// Assumes: Included by bare name from every design file that needs a constant.
// Notes:   Definitions only.
`ifndef AIQ_REGS_SVH
`define AIQ_REGS_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// -----------------------------------------------------------------------------
`define AIQ_OFS_CTRL 8'h00
`define AIQ_OFS_SCALE 8'h04
`define AIQ_OFS_STATUS 8'h08
`define AIQ_OFS_INT_EN 8'h0c
`define AIQ_OFS_INT_CLR 8'h10
`define AIQ_OFS_POINTS 8'h14
`define AIQ_OFS_HEADER 8'h18

// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define AIQ_CTRL_PLAY 0
`define AIQ_CTRL_LEGACY 1
`define AIQ_CTRL_INTERP 2
`define AIQ_ST_OVR 0
`define AIQ_ST_DONE 1
`define AIQ_ST_SHORT 2
`define AIQ_ST_MRKDEF 3
`define AIQ_HDR_SPEC 31
`define AIQ_PTS_OK 16
`define AIQ_SCALE_RST 7'h46
`define AIQ_SCALE_FULL 7'h64
`define AIQ_RATE_RST 16'h0003

// -----------------------------------------------------------------------------
// Sample encodings and limits
// -----------------------------------------------------------------------------
`define AIQ_DEPTH 256
`define AIQ_PTR_FULL 9'h100
`define AIQ_MIN_POINTS 9'h03c
`define AIQ_LEG_ZERO 14'h2000
`define AIQ_POS_FULL 16'h7fff
`define AIQ_NEG_FULL 16'h8000

`endif

// File: core/aiq_pkg.sv
// Purpose: Types shared by the sample unpacker files.
// Assumes: Constants live in aiq_regs.svh.
// Notes:   Nothing here is imported; users write aiq_pkg::name.
package aiq_pkg;

  // Download stream state: idle, sample file or marker file in progress.
  typedef enum logic [1:0] {
    AIQ_DL_IDLE = 2'b00,
    AIQ_DL_IQ = 2'b01,
    AIQ_DL_MRK = 2'b10
  } aiq_dl_e;

endpackage : aiq_pkg

// File: core/aiq_sample_conv.sv
// Purpose: One channel of the sample path: format conversion, scaling, 2x interpolation.
// Assumes: load_i and mid_i never both high; scale_i is at most 100.
// Notes:   Output and overload flag are registered.
`timescale 1ns/100ps
`include "aiq_regs.svh"

module aiq_sample_conv (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Sample and settings.
  input wire logic [15:0] raw_i,
  input wire logic legacy_i,
  input wire logic [6:0] scale_i,
  // Strobes: load a new point, or emit the interpolated midpoint.
  input wire logic load_i,
  input wire logic mid_i,
  // DAC code and one-cycle overload pulse.
  output logic [15:0] dac_o,
  output logic ovr_o
);

  // ---------------------------------------------------------------------------
  // Conversion and scaling
  // ---------------------------------------------------------------------------
  // Offset binary 14-bit legacy data becomes signed by flipping its top bit.
  logic signed [15:0] signed_w;
  logic signed [23:0] prod_w;
  logic signed [15:0] scaled_w;
  assign signed_w = legacy_i ? {~raw_i[13], raw_i[12:0], 2'b00} : raw_i;
  assign prod_w = 24'(signed_w) * $signed({17'h00000, scale_i});
  assign scaled_w = 16'(prod_w / $signed(24'h000064));

  // ---------------------------------------------------------------------------
  // History and half-band midpoint
  // ---------------------------------------------------------------------------
  // Newest sample in h0_ff; the midpoint lies between h2_ff and h1_ff.
  logic signed [15:0] h0_ff, h1_ff, h2_ff, h3_ff;
  logic signed [21:0] acc_w;
  logic signed [21:0] mid_full_w;
  logic over_w;
  logic [15:0] mid_sat_w;
  // The four-tap kernel overshoots on sharp edges, which is what trips overload.
  assign acc_w = 22'sd9 * (22'(h1_ff) + 22'(h2_ff)) - (22'(h0_ff) + 22'(h3_ff));
  assign mid_full_w = acc_w >>> 4;
  assign over_w = (mid_full_w > 22'sd32767) || (mid_full_w < -22'sd32768);
  assign mid_sat_w = !over_w ? mid_full_w[15:0]
                   : (mid_full_w[21] ? `AIQ_NEG_FULL : `AIQ_POS_FULL);

  // History shift and output register; the DAC follows two points behind input.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      h0_ff <= 16'h0000;
      h1_ff <= 16'h0000;
      h2_ff <= 16'h0000;
      h3_ff <= 16'h0000;
      dac_o <= 16'h0000;
      ovr_o <= 1'b0;
    end
    else
    begin
      ovr_o <= mid_i && over_w;
      if (load_i)
      begin
        h0_ff <= scaled_w;
        h1_ff <= h0_ff;
        h2_ff <= h1_ff;
        h3_ff <= h2_ff;
        dac_o <= h1_ff;
      end
      else if (mid_i)
      begin
        dac_o <= mid_sat_w;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_legacy_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    legacy_i && raw_i[13:0] == `AIQ_LEG_ZERO |-> signed_w == 16'h0000)
    else $error("legacy mid code not converted to zero");
  a_ovr_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mid_i && over_w |=> ovr_o && (dac_o == `AIQ_POS_FULL || dac_o == `AIQ_NEG_FULL))
    else $error("overshoot not flagged or not saturated");

endmodule : aiq_sample_conv

// File: core/aiq_unpacker.sv
// Purpose: Waveform sample unpacker: download, storage, playback, markers, registers.
// Assumes: Host streams bytes one per valid cycle and marks each file's last byte.
// Notes:   Point memory holds 256 points; extra points of a longer file are dropped.
//
// Behaviour
// - Each I and Q feeds 16-bit DAC.
// - 32767 full positive, 0 zero, -32768 negative.
// - Samples are signed two's complement.
// - Legacy: unsigned 14 bits, 8192 is zero.
// - Legacy samples converted to signed codes.
// - Flag overload when interpolation overshoots.
// - Percentage amplitude scaling, preset to 70.
// - Stream interleaves I then Q per point.
// - Sample download makes header unspecified.
// - One marker byte per waveform point.
// - Marker bits 0-3 drive markers one-four.
// - Active marker drives output; marker one event.
// - Missing marker data means cleared markers.
// - Marker download replaces markers, keeps samples.
// - Sample re-download zeroes stored markers.
// - Two-byte samples arrive high byte first.
// - Waveforms under 60 points never play.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "aiq_regs.svh"

module aiq_unpacker (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Download byte stream.
  input wire logic DL_VALID_I,
  input wire logic [7:0] DL_DATA_I,
  input wire logic DL_MARKER_I,
  input wire logic DL_LAST_I,
  // Playback outputs.
  output logic [15:0] DAC_I_O,
  output logic [15:0] DAC_Q_O,
  output logic [3:0] MARKER_O,
  output logic EVENT1_O,
  output logic PLAY_ACTIVE_O,
  // Interrupt.
  output logic IRQ_O
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [2:0] ctrl_ff; // Play, legacy format, interpolation enable.
  logic [6:0] scale_ff; // Amplitude in percent of full scale.
  logic [3:0] status_ff; // Sticky event bits.
  logic [3:0] int_en_ff; // Interrupt enables, same layout as status.
  logic [15:0] hdr_rate_ff; // Header playback rate setting.
  logic hdr_spec_ff; // Header setting is specified.
  logic [15:0] eff_rate_ff; // Rate in force, kept from the last played waveform.

  // ---------------------------------------------------------------------------
  // Download state and memories
  // ---------------------------------------------------------------------------
  aiq_pkg::aiq_dl_e dl_state_ff;
  logic [1:0] byte_cnt_ff; // Byte position inside an I/Q point.
  logic [7:0] hi_byte_ff; // First (high) byte of a sample.
  logic [15:0] i_word_ff; // Completed I sample awaiting its Q.
  logic [8:0] wr_ptr_ff; // Next point index to write.
  logic [8:0] iq_cnt_ff; // Points of the stored waveform.
  logic [8:0] mrk_cnt_ff; // Marker bytes stored; beyond it markers read zero.
  logic wave_ok_ff; // Stored waveform long enough to play.
  logic [31:0] iq_mem [`AIQ_DEPTH]; // I in the upper half, Q in the lower.
  logic [3:0] mrk_mem [`AIQ_DEPTH]; // Marker nibble per point.

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  logic wr_ctrl_w, wr_scale_w, wr_en_w, wr_clr_w, wr_hdr_w;
  logic [6:0] scale_wr_w;
  logic [31:0] rd_mux_w;
  assign wr_ctrl_w = WR_I && ADDR_I == `AIQ_OFS_CTRL;
  assign wr_scale_w = WR_I && ADDR_I == `AIQ_OFS_SCALE;
  assign wr_en_w = WR_I && ADDR_I == `AIQ_OFS_INT_EN;
  assign wr_clr_w = WR_I && ADDR_I == `AIQ_OFS_INT_CLR;
  assign wr_hdr_w = WR_I && ADDR_I == `AIQ_OFS_HEADER;
  // Settings above full scale are clamped so the product can never overflow.
  assign scale_wr_w = (WDATA_I > 32'(`AIQ_SCALE_FULL)) ? `AIQ_SCALE_FULL : WDATA_I[6:0];
  assign rd_mux_w = (ADDR_I == `AIQ_OFS_CTRL) ? {29'h00000000, ctrl_ff}
                  : (ADDR_I == `AIQ_OFS_SCALE) ? {25'h0000000, scale_ff}
                  : (ADDR_I == `AIQ_OFS_STATUS) ? {28'h0000000, status_ff}
                  : (ADDR_I == `AIQ_OFS_INT_EN) ? {28'h0000000, int_en_ff}
                  : (ADDR_I == `AIQ_OFS_POINTS) ? {15'h0000, wave_ok_ff, 7'h00, iq_cnt_ff}
                  : (ADDR_I == `AIQ_OFS_HEADER) ? {hdr_spec_ff, 15'h0000, hdr_rate_ff}
                  : 32'h00000000;

  // ---------------------------------------------------------------------------
  // Download decode
  // ---------------------------------------------------------------------------
  logic dl_start_w, dl_is_mrk_w, iq_wr_w, mrk_wr_w, dl_end_w;
  logic [1:0] cnt_w;
  logic [8:0] ptr_w, ptr_nxt_w;
  logic [3:0] mrk_byte_w;
  assign dl_start_w = DL_VALID_I && dl_state_ff == aiq_pkg::AIQ_DL_IDLE;
  assign dl_is_mrk_w = dl_start_w ? DL_MARKER_I : (dl_state_ff == aiq_pkg::AIQ_DL_MRK);
  assign cnt_w = dl_start_w ? 2'b00 : byte_cnt_ff;
  assign ptr_w = dl_start_w ? 9'h000 : wr_ptr_ff;
  // A point is written on its fourth byte: I high, I low, Q high, Q low.
  assign iq_wr_w = DL_VALID_I && !dl_is_mrk_w && cnt_w == 2'b11 && ptr_w != `AIQ_PTR_FULL;
  assign mrk_wr_w = DL_VALID_I && dl_is_mrk_w && ptr_w != `AIQ_PTR_FULL;
  assign ptr_nxt_w = ptr_w + {8'h00, iq_wr_w | mrk_wr_w};
  assign dl_end_w = DL_VALID_I && DL_LAST_I;
  // Reserved marker bits 4-7 are dropped here.
  assign mrk_byte_w = DL_DATA_I[3:0];

  // ---------------------------------------------------------------------------
  // Playback decode
  // ---------------------------------------------------------------------------
  logic run_w, run_d_ff, tick_w, phase_ff, load_w, mid_w;
  logic [15:0] div_ff;
  logic [7:0] rd_idx_ff;
  logic [31:0] iq_rd_ff;
  logic [3:0] mrk_rd_ff, mk_d0_ff, mk_d1_ff;
  logic [3:0] mrk_src_w;
  logic ovr_i_w, ovr_q_w;
  logic [3:0] set_w;
  // Playback only while idle on the download side and the stored waveform is valid.
  assign run_w = ctrl_ff[`AIQ_CTRL_PLAY] && wave_ok_ff &&
                 dl_state_ff == aiq_pkg::AIQ_DL_IDLE;
  assign tick_w = run_w && run_d_ff && div_ff == 16'h0000;
  assign load_w = tick_w && !phase_ff;
  assign mid_w = tick_w && phase_ff && ctrl_ff[`AIQ_CTRL_INTERP];
  // Legacy data carries two markers in the top bits of the I sample.
  assign mrk_src_w = ctrl_ff[`AIQ_CTRL_LEGACY] ? {2'b00, iq_rd_ff[30], iq_rd_ff[31]} : mrk_rd_ff;

  // Event sources for the sticky status bits.
  assign set_w[`AIQ_ST_OVR] = ovr_i_w | ovr_q_w;
  assign set_w[`AIQ_ST_DONE] = dl_end_w;
  assign set_w[`AIQ_ST_SHORT] = dl_end_w && !dl_is_mrk_w && ptr_nxt_w < `AIQ_MIN_POINTS;
  assign set_w[`AIQ_ST_MRKDEF] = dl_end_w && !dl_is_mrk_w;

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  // Control, scaling, enables and the read answer.
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ctrl_ff <= 3'h0;
      scale_ff <= `AIQ_SCALE_RST;
      int_en_ff <= 4'h0;
      RDATA_O <= 32'h00000000;
      IRQ_O <= 1'b0;
    end
    else
    begin
      if (wr_ctrl_w) ctrl_ff <= WDATA_I[2:0];
      if (wr_scale_w) scale_ff <= scale_wr_w;
      if (wr_en_w) int_en_ff <= WDATA_I[3:0];
      RDATA_O <= RD_I ? rd_mux_w : 32'h00000000;
      IRQ_O <= |(status_ff & int_en_ff);
    end
  end

  // Sticky status: a set in the same cycle as its clear survives.
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      status_ff <= 4'h0;
    end
    else
    begin
      status_ff <= (status_ff & ~(wr_clr_w ? WDATA_I[3:0] : 4'h0)) | set_w;
    end
  end

  // Header: a fresh sample download leaves it unspecified, so the rate in force
  // stays at whatever the previous waveform used.
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      hdr_rate_ff <= `AIQ_RATE_RST;
      hdr_spec_ff <= 1'b0;
      eff_rate_ff <= `AIQ_RATE_RST;
    end
    else
    begin
      if (dl_start_w && !DL_MARKER_I)
      begin
        hdr_spec_ff <= 1'b0;
      end
      else if (wr_hdr_w)
      begin
        hdr_rate_ff <= WDATA_I[15:0];
        hdr_spec_ff <= WDATA_I[`AIQ_HDR_SPEC];
      end
      if (run_w && !run_d_ff && hdr_spec_ff) eff_rate_ff <= hdr_rate_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Download engine
  // ---------------------------------------------------------------------------
  // Stream state, byte pairing and point counts.
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      dl_state_ff <= aiq_pkg::AIQ_DL_IDLE;
      byte_cnt_ff <= 2'b00;
      hi_byte_ff <= 8'h00;
      i_word_ff <= 16'h0000;
      wr_ptr_ff <= 9'h000;
      iq_cnt_ff <= 9'h000;
      mrk_cnt_ff <= 9'h000;
      wave_ok_ff <= 1'b0;
    end
    else if (DL_VALID_I)
    begin
      byte_cnt_ff <= cnt_w + 2'b01;
      wr_ptr_ff <= ptr_nxt_w;
      // High byte is held, low byte completes the sample.
      if (!cnt_w[0]) hi_byte_ff <= DL_DATA_I;
      if (cnt_w == 2'b01) i_word_ff <= {hi_byte_ff, DL_DATA_I};
      if (dl_start_w && !DL_MARKER_I)
      begin
        // Old markers are void the moment new samples start arriving.
        wave_ok_ff <= 1'b0;
        mrk_cnt_ff <= 9'h000;
      end
      if (dl_end_w)
      begin
        dl_state_ff <= aiq_pkg::AIQ_DL_IDLE;
        if (dl_is_mrk_w)
        begin
          mrk_cnt_ff <= ptr_nxt_w;
        end
        else
        begin
          iq_cnt_ff <= ptr_nxt_w;
          wave_ok_ff <= ptr_nxt_w >= `AIQ_MIN_POINTS;
        end
      end
      else
      begin
        case (dl_state_ff)
          aiq_pkg::AIQ_DL_IDLE: dl_state_ff <= DL_MARKER_I ? aiq_pkg::AIQ_DL_MRK
                                                          : aiq_pkg::AIQ_DL_IQ;
          aiq_pkg::AIQ_DL_IQ: dl_state_ff <= aiq_pkg::AIQ_DL_IQ;
          aiq_pkg::AIQ_DL_MRK: dl_state_ff <= aiq_pkg::AIQ_DL_MRK;
          default: dl_state_ff <= aiq_pkg::AIQ_DL_IDLE;
        endcase
      end
    end
  end

  // Memory writes carry no reset; the counts decide what is valid.
  always_ff @(posedge CLK_I)
  begin
    if (iq_wr_w) iq_mem[ptr_w[7:0]] <= {i_word_ff, hi_byte_ff, DL_DATA_I};
    if (mrk_wr_w) mrk_mem[ptr_w[7:0]] <= mrk_byte_w;
  end

  // ---------------------------------------------------------------------------
  // Playback sequencer
  // ---------------------------------------------------------------------------
  // Rate divider, point index, memory read and marker alignment.
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      run_d_ff <= 1'b0;
      div_ff <= 16'h0000;
      phase_ff <= 1'b0;
      rd_idx_ff <= 8'h00;
      iq_rd_ff <= 32'h00000000;
      mrk_rd_ff <= 4'h0;
      mk_d0_ff <= 4'h0;
      mk_d1_ff <= 4'h0;
      MARKER_O <= 4'h0;
      EVENT1_O <= 1'b0;
      PLAY_ACTIVE_O <= 1'b0;
    end
    else
    begin
      run_d_ff <= run_w;
      PLAY_ACTIVE_O <= run_w;
      iq_rd_ff <= iq_mem[rd_idx_ff];
      // Points past the stored marker count read as all markers off.
      mrk_rd_ff <= ({1'b0, rd_idx_ff} < mrk_cnt_ff) ? mrk_mem[rd_idx_ff] : 4'h0;
      if (!run_w)
      begin
        div_ff <= 16'h0000;
        phase_ff <= 1'b0;
        rd_idx_ff <= 8'h00;
      end
      else if (tick_w)
      begin
        div_ff <= eff_rate_ff;
        phase_ff <= ~phase_ff;
      end
      else if (run_d_ff)
      begin
        div_ff <= div_ff - 16'h0001;
      end
      if (load_w)
      begin
        // The index wraps so a finite waveform repeats.
        rd_idx_ff <= ({1'b0, rd_idx_ff} + 9'h001 >= iq_cnt_ff) ? 8'h00 : rd_idx_ff + 8'h01;
        // Two stages keep markers aligned with the DAC, which lags by two points.
        mk_d0_ff <= mrk_src_w;
        mk_d1_ff <= mk_d0_ff;
        MARKER_O <= mk_d1_ff;
        EVENT1_O <= mk_d1_ff[0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Channel converters
  // ---------------------------------------------------------------------------
  aiq_sample_conv u_conv_i (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .raw_i(iq_rd_ff[31:16]),
    .legacy_i(ctrl_ff[`AIQ_CTRL_LEGACY]),
    .scale_i(scale_ff),
    .load_i(load_w),
    .mid_i(mid_w),
    .dac_o(DAC_I_O),
    .ovr_o(ovr_i_w)
  );

  aiq_sample_conv u_conv_q (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .raw_i(iq_rd_ff[15:0]),
    .legacy_i(ctrl_ff[`AIQ_CTRL_LEGACY]),
    .scale_i(scale_ff),
    .load_i(load_w),
    .mid_i(mid_w),
    .dac_o(DAC_Q_O),
    .ovr_o(ovr_q_w)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_scale_bound: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wr_scale_w |=> scale_ff <= `AIQ_SCALE_FULL && scale_ff == $past(scale_wr_w))
    else $error("scaling setting out of range");
  a_event_marker: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    load_w |=> EVENT1_O == MARKER_O[0] && MARKER_O == $past(mk_d1_ff))
    else $error("event output not following marker one");
  a_iq_zeroes_mrk: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    dl_start_w && !DL_MARKER_I |=> mrk_cnt_ff == 9'h000)
    else $error("markers not voided by sample download");
  a_short_reject: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    dl_end_w && !dl_is_mrk_w |=> wave_ok_ff == (iq_cnt_ff >= `AIQ_MIN_POINTS))
    else $error("waveform length check wrong");
  a_mrk_keeps_iq: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    DL_VALID_I && dl_is_mrk_w |=> $stable(iq_cnt_ff) && $stable(wave_ok_ff))
    else $error("marker download disturbed samples");
  a_ovr_sticky: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    status_ff[`AIQ_ST_OVR] && !(wr_clr_w && WDATA_I[`AIQ_ST_OVR]) |=> status_ff[`AIQ_ST_OVR])
    else $error("overload flag dropped without a clear");
  a_hdr_unspec: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    dl_start_w && !DL_MARKER_I |=> !hdr_spec_ff)
    else $error("header not unspecified after sample download");
  c_play: cover property (@(posedge CLK_I) disable iff (!RSTN_I) load_w ##[1:40] load_w);
  c_ovr: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $rose(status_ff[`AIQ_ST_OVR]));
  c_mrk: cover property (@(posedge CLK_I) disable iff (!RSTN_I) mrk_wr_w ##[1:20] dl_end_w);

endmodule : aiq_unpacker

// File: test/aiq_host_model.sv
// Purpose: Host model that streams sample and marker files into the unpacker.
// Assumes: Kind 0 full scale, 1 legacy, 2 overshoot pattern, 3 marker file.
// Notes:   Idle data lines show the inverse of the last byte, never a stale copy.
`timescale 1ns/100ps

module aiq_host_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // File request, held stable while busy.
  input wire logic start_i,
  input wire logic [1:0] kind_i,
  input wire logic [8:0] npts_i,
  output logic busy_o,
  // Byte stream.
  output logic dl_valid_o,
  output logic [7:0] dl_data_o,
  output logic dl_marker_o,
  output logic dl_last_o
);
  logic [10:0] idx_ff; // Byte index within the file.
  logic [10:0] total; // File length in bytes.
  logic [15:0] smp; // Sample that owns the current byte.
  logic [7:0] byte_v; // Current byte before the idle inversion.
  logic [8:0] pnt; // Point that owns the current byte.
  // Marker files carry one byte per point, sample files four.
  assign total = (kind_i == 2'd3) ? {2'b00, npts_i} : {npts_i, 2'b00};
  assign pnt = idx_ff[10:2];
  always_comb
  begin
    case (kind_i)
      2'd0: smp = idx_ff[1] ? 16'h8000 : 16'h7fff;
      2'd1: smp = idx_ff[1] ? 16'h0000 : 16'hffff;
      default: smp = pnt[1] ? 16'h8000 : 16'h7fff;
    endcase
  end
  // High byte first; markers one and three on, reserved bits zero.
  assign byte_v = (kind_i == 2'd3) ? 8'h05 : (idx_ff[0] ? smp[7:0] : smp[15:8]);
  assign dl_data_o = busy_o ? byte_v : ~byte_v;
  assign dl_valid_o = busy_o;
  assign dl_marker_o = busy_o & (kind_i == 2'd3);
  assign dl_last_o = busy_o & (idx_ff == total - 11'd1);
  // One byte every cycle from start until the last byte.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_o <= 1'b0;
      idx_ff <= 11'h000;
    end
    else if (!busy_o && start_i)
    begin
      busy_o <= 1'b1;
      idx_ff <= 11'h000;
    end
    else if (dl_last_o)
      busy_o <= 1'b0;
    else if (busy_o)
      idx_ff <= idx_ff + 11'd1;
  end
endmodule : aiq_host_model

// File: test/testbench.sv
// Purpose: Self-checking bench for the sample unpacker.
// Assumes: Playback rate stays at its reset value of three.
// Notes:   Constant waveforms let levels be checked without exact playback timing.
`timescale 1ns/100ps
`include "aiq_regs.svh"

module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic start = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [8:0] npts = 9'h000;
  logic [31:0] rdata;
  logic [15:0] dac_i, dac_q;
  logic [3:0] mrk;
  logic ev1, act, irq, busy, dv, dm, dlast;
  logic [7:0] dd;
  int mismatches = 0;
  int checked = 0;
  always #5 clk = ~clk;
  aiq_host_model i_host (.clk_i(clk), .rstn_i(rstn), .start_i(start), .kind_i(kind),
    .npts_i(npts), .busy_o(busy), .dl_valid_o(dv), .dl_data_o(dd), .dl_marker_o(dm),
    .dl_last_o(dlast));
  aiq_unpacker i_dut (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DL_VALID_I(dv), .DL_DATA_I(dd),
    .DL_MARKER_I(dm), .DL_LAST_I(dlast), .DAC_I_O(dac_i), .DAC_Q_O(dac_q),
    .MARKER_O(mrk), .EVENT1_O(ev1), .PLAY_ACTIVE_O(act), .IRQ_O(irq));
  task automatic summarize();
    $display("Counts: %0d mismatches in %0d checks", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe.
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rreg
  // Starts one file and waits, bounded, for the host to finish it.
  task automatic dl(input logic [1:0] k, input logic [8:0] n);
    int t;
    @(posedge clk);
    kind <= k;
    npts <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (t = 0; t < 2000 && (busy || t < 2); t++)
      @(posedge clk);
    if (busy)
    begin
      mismatches++;
      summarize();
    end
    repeat (2) @(posedge clk);
  endtask : dl
  // Plays long enough for the two-point output lag to pass, then samples.
  task automatic play(input logic [31:0] c);
    wreg(`AIQ_OFS_CTRL, c);
    repeat (100) @(posedge clk);
    #1;
  endtask : play
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rreg(`AIQ_OFS_SCALE, 32'h46);
    rreg(8'h1c, 32'h0);
    wreg(`AIQ_OFS_HEADER, 32'h80000003);
    rreg(`AIQ_OFS_HEADER, 32'h80000003);
    dl(2'd0, 9'd1);
    rreg(`AIQ_OFS_POINTS, 32'h1);
    rreg(`AIQ_OFS_STATUS, 32'he);
    rreg(`AIQ_OFS_HEADER, 32'h3);
    play(32'h1);
    chk({26'h0, act, ev1, mrk}, 32'h0);
    wreg(`AIQ_OFS_CTRL, 32'h0);
    wreg(`AIQ_OFS_INT_CLR, 32'hf);
    dl(2'd0, 9'd60);
    rreg(`AIQ_OFS_POINTS, 32'h1003c);
    rreg(`AIQ_OFS_STATUS, 32'ha);
    play(32'h1);
    chk({dac_q, dac_i}, 32'ha6675998);
    chk({26'h0, act, ev1, mrk}, 32'h20);
    wreg(`AIQ_OFS_SCALE, 32'hc8);
    rreg(`AIQ_OFS_SCALE, 32'h64);
    wreg(`AIQ_OFS_CTRL, 32'h0);
    dl(2'd3, 9'd60);
    play(32'h1);
    chk({dac_q, dac_i}, 32'h80007fff);
    chk({26'h0, act, ev1, mrk}, 32'h35);
    wreg(`AIQ_OFS_CTRL, 32'h0);
    dl(2'd0, 9'd60);
    play(32'h1);
    chk({26'h0, act, ev1, mrk}, 32'h20);
    wreg(`AIQ_OFS_CTRL, 32'h0);
    dl(2'd1, 9'd60);
    play(32'h3);
    chk({dac_q, dac_i}, 32'h80007ffc);
    chk({26'h0, act, ev1, mrk}, 32'h33);
    wreg(`AIQ_OFS_CTRL, 32'h0);
    wreg(`AIQ_OFS_INT_CLR, 32'hf);
    wreg(`AIQ_OFS_INT_EN, 32'h1);
    dl(2'd2, 9'd60);
    play(32'h5);
    wreg(`AIQ_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    rreg(`AIQ_OFS_STATUS, 32'hb);
    wreg(`AIQ_OFS_INT_EN, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wreg(`AIQ_OFS_INT_EN, 32'h1);
    wreg(`AIQ_OFS_INT_CLR, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rreg(`AIQ_OFS_STATUS, 32'ha);
    summarize();
  end
endmodule : testbench
